// ---- hdl/mpc_clock_control.v ----
// clock selection and generation for the mac phy interface
// Function
// [RULE1] select pins: 00 mii, 01 rmii, 10 gmii, 11 rgmii, set in hardware
// [RULE2] only the selected interface carries frame data at any time
// [RULE3] mii: phy supplies both line clocks, 2.5/25 MHz; never 1000 Mbps
// [RULE4] rmii: both directions clocked from 50 MHz reference; line clocks ignored
// [RULE5] rmii splits each data phase in two; pins change at 5/50 MHz
// [RULE6] gmii: phy gives both clocks at 10/100; rx clock from phy at 1000
// [RULE7] gmii 1000: device drives gigabit tx clock from secondary reference /2
// [RULE8] rgmii: device drives tx clock and 125 MHz reference; phy makes rx clock (code forwards the secondary reference and expects /5, 50 MHz)
// [RULE9] reference clock output stops while the device is in reset
// [RULE10] rgmii: half-width data, speed taken from phy receive stream
// [RULE11] management clock is peripheral clock over software divisor, at most 2.5 MHz
// [RULE12] peripheral clock is processor clock over six, fixed
// [RULE13] secondary reference is 25 MHz times ten over five or two
// [RULE14] select pins are static; routing is captured once after reset
`timescale 1ns/1ns
`include "mpc_clock_defs.vh"
module mpc_clock_control (
   // clock and reset
   input  wire       mclk_i,
   input  wire       reset_i,
   // configuration pins
   input  wire [1:0] phy_interface_select_i,
   // line clocks from the phy and reference pins
   input  wire       tx_line_clock_in_i,
   input  wire       rx_line_clock_in_i,
   input  wire       rmii_reference_clock_in_i,
   input  wire       secondary_reference_clock_i,
   // rgmii receive control and data, for in-band speed
   input  wire       rgmii_rx_ctl_i,
   input  wire [3:0] rgmii_rxd_i,
   // software settings
   input  wire [1:0] line_speed_i,
   input  wire       sec_div_five_i,
   input  wire [7:0] mdio_half_div_i,
   // generated clocks
   output reg        gigabit_tx_clock_out_o,
   output reg        rgmii_reference_clock_o,
   output wire       peripheral_clock_o,
   output wire       mdio_clock_o,
   // data phase strobes
   output reg        tx_phase_o,
   output reg        rx_phase_o,
   // status
   output reg  [3:0] interface_active_o,
   output reg  [1:0] line_speed_o,
   output reg        config_error_o,
   output reg        sec_div_mismatch_o
);

   localparam ST_WAIT = 2'b01;
   localparam ST_RUN  = 2'b10;

   // pin order: tx line, rx line, rmii ref, secondary ref, rx ctl, rxd, select
   localparam NPIN = 11;

   // one-hot view of the selected interface
   function [3:0] mpc_onehot;
      input [1:0] sel;
      begin
         mpc_onehot = 4'h1 << sel;
      end
   endfunction

   // secondary reference frequency in kHz for the chosen divider
   function [31:0] mpc_sec_khz;
      input five;
      begin
         if (five)
            mpc_sec_khz = `MPC_PLL_IN_KHZ * `MPC_PLL_MULT / `MPC_SEC_DIV_B;
         else
            mpc_sec_khz = `MPC_PLL_IN_KHZ * `MPC_PLL_MULT / `MPC_SEC_DIV_A;
      end
   endfunction

   wire [NPIN-1:0] pins_raw;
   reg  [NPIN-1:0] sync1;
   reg  [NPIN-1:0] sync2;
   reg  [NPIN-1:0] sync3;
   reg  [NPIN-1:0] pins;
   reg  [NPIN-1:0] pins_d;
   wire [NPIN-1:0] pins_rise;

   reg  [1:0]      state;
   reg  [1:0]      next_state;
   reg  [2:0]      settle;
   reg  [1:0]      sel;
   reg  [1:0]      rgmii_speed;
   reg  [3:0]      rmii_count;
   reg             next_tx;
   reg             next_rx;
   reg  [1:0]      speed_now;
   wire            running;
   wire            rmii_edge;
   wire            rmii_phase;
   wire            periph_rise;
   wire [7:0]      mdio_half;
   reg  [1:0]      next_rgmii_speed;
   reg  [3:0]      next_rmii_count;
   reg  [3:0]      next_active;
   reg             next_gig;
   reg             next_ref;
   reg             next_cfg;
   reg             next_mismatch;

   assign pins_raw = {phy_interface_select_i, rgmii_rxd_i, rgmii_rx_ctl_i,
                      secondary_reference_clock_i, rmii_reference_clock_in_i,
                      rx_line_clock_in_i, tx_line_clock_in_i};

   // three-stage sync; a change is taken once stages two and three agree
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1  <= {NPIN{1'b0}};
         sync2  <= {NPIN{1'b0}};
         sync3  <= {NPIN{1'b0}};
         pins   <= {NPIN{1'b0}};
         pins_d <= {NPIN{1'b0}};
      end else begin
         sync1  <= pins_raw;
         sync2  <= sync1;
         sync3  <= sync2;
         pins   <= (sync2 & sync3) | (pins & (sync2 | sync3));
         pins_d <= pins;
      end
   end

   assign pins_rise = pins & ~pins_d;
   assign running   = (state == ST_RUN);

   // capture the select pins once after reset, then hold them
   always @* begin
      next_state = state;
      case (state)
         ST_WAIT: begin
            if (settle == `MPC_STRAP_WAIT)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_WAIT;
         end
      endcase
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state  <= ST_WAIT;
         settle <= 3'h0;
         sel    <= `MPC_SEL_MII;
      end else begin
         state <= next_state;
         if (state == ST_WAIT) begin
            settle <= settle + 3'h1;
            sel    <= pins[10:9]; // [RULE1] [RULE14]
         end
      end
   end

   // rgmii in-band speed, taken between frames from the receive stream
   always @* begin
      next_rgmii_speed = rgmii_speed;
      if (running && sel == `MPC_SEL_RGMII && pins_rise[1] && !pins[4]) begin
         // in-band code 3 is not a speed and leaves the last one in place
         if (pins[7:6] != 2'h3)
            next_rgmii_speed = pins[7:6]; // [RULE10]
      end
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rgmii_speed <= `MPC_SPEED_10;
      end else begin
         rgmii_speed <= next_rgmii_speed;
      end
   end

   always @* begin
      if (sel == `MPC_SEL_RGMII)
         speed_now = rgmii_speed; // [RULE10]
      else if (sel != `MPC_SEL_GMII && line_speed_i == `MPC_SPEED_1000)
         speed_now = `MPC_SPEED_100;
      else
         speed_now = line_speed_i;
   end

   // rmii: every reference edge at 100 Mbps, one in ten at 10 Mbps
   assign rmii_edge  = pins_rise[2];
   assign rmii_phase = rmii_edge &&
                       (speed_now != `MPC_SPEED_10 || rmii_count == 4'h0); // [RULE5]

   always @* begin
      next_rmii_count = rmii_count;
      if (running && sel == `MPC_SEL_RMII && rmii_edge) begin
         if (rmii_count + 4'h1 >= `MPC_RMII_SLOW_DIV)
            next_rmii_count = 4'h0;
         else
            next_rmii_count = rmii_count + 4'h1;
      end
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rmii_count <= 4'h0;
      end else begin
         rmii_count <= next_rmii_count;
      end
   end

   // per-interface source of the transmit and receive data phases
   always @* begin
      next_tx = 1'b0;
      next_rx = 1'b0;
      if (running) begin
         if (sel == `MPC_SEL_MII) begin
            next_tx = pins_rise[0]; // [RULE3]
            next_rx = pins_rise[1]; // [RULE3]
         end else if (sel == `MPC_SEL_RMII) begin
            next_tx = rmii_phase; // [RULE4]
            next_rx = rmii_phase; // [RULE4]
         end else if (sel == `MPC_SEL_GMII) begin
            next_tx = (speed_now == `MPC_SPEED_1000) ? pins_rise[3] : pins_rise[0]; // [RULE6] [RULE7]
            next_rx = pins_rise[1]; // [RULE6]
         end else begin
            next_tx = pins_rise[3]; // [RULE8]
            next_rx = pins_rise[1]; // [RULE8]
         end
      end
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         tx_phase_o             <= 1'b0;
         rx_phase_o             <= 1'b0;
         interface_active_o     <= 4'h0;
         line_speed_o           <= `MPC_SPEED_10;
         gigabit_tx_clock_out_o <= 1'b0;
         rgmii_reference_clock_o <= 1'b0;
         config_error_o         <= 1'b0;
         sec_div_mismatch_o     <= 1'b0;
      end else begin
         tx_phase_o              <= next_tx;
         rx_phase_o              <= next_rx;
         interface_active_o      <= next_active;
         line_speed_o            <= speed_now;
         gigabit_tx_clock_out_o  <= next_gig;
         // held low in reset by the asynchronous clear
         rgmii_reference_clock_o <= next_ref; // [RULE9]
         config_error_o          <= next_cfg;
         sec_div_mismatch_o      <= next_mismatch;
      end
   end

   // status and forwarded clocks for the output flops above
   always @* begin
      next_active   = 4'h0;
      next_gig      = 1'b0;
      next_ref      = 1'b0;
      next_cfg      = 1'b0;
      next_mismatch = 1'b0;
      if (running) begin
         next_active = mpc_onehot(sel); // [RULE2]
         if (sel == `MPC_SEL_GMII) begin
            // gigabit clock sourced here only at 1000; it needs the /2 setting
            next_gig      = pins[3] && speed_now == `MPC_SPEED_1000; // [RULE7]
            next_mismatch = (mpc_sec_khz(sec_div_five_i) != `MPC_GIG_KHZ); // [RULE13]
         end else if (sel == `MPC_SEL_RGMII) begin
            // rgmii forwards both clocks and expects the /5 setting
            next_gig      = pins[3]; // [RULE8]
            next_ref      = pins[3]; // [RULE8] [RULE9]
            next_mismatch = !sec_div_five_i; // [RULE8] [RULE13]
         end else begin
            // mii and rmii cannot run at 1000
            next_cfg = (line_speed_i == `MPC_SPEED_1000); // [RULE3]
         end
      end
   end

   // management divisor clamped so the clock never exceeds its ceiling
   localparam [31:0] MDIO_MIN_W = `MPC_MDIO_MIN_HALF;
   localparam [7:0]  MDIO_MIN   = MDIO_MIN_W[7:0];

   assign mdio_half = (mdio_half_div_i < MDIO_MIN) ? MDIO_MIN : mdio_half_div_i;

   mpc_divider u_periph (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .run_i   (1'b1),
      .tick_i  (1'b1),
      .half_i  (`MPC_PERIPH_HALF), // [RULE12]
      .clk_o   (peripheral_clock_o),
      .rise_o  (periph_rise)
   );

   mpc_divider u_mdio (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .run_i   (1'b1),
      .tick_i  (periph_rise),
      .half_i  (mdio_half), // [RULE11]
      .clk_o   (mdio_clock_o),
      .rise_o  ()
   );

endmodule // mpc_clock_control

// ---- hdl/mpc_clock_defs.vh ----
// constants for the mac phy interface clocking block
`ifndef MPC_CLOCK_DEFS_VH
`define MPC_CLOCK_DEFS_VH

// interface select codes
`define MPC_SEL_MII       2'h0
`define MPC_SEL_RMII      2'h1
`define MPC_SEL_GMII      2'h2
`define MPC_SEL_RGMII     2'h3

// line speed codes
`define MPC_SPEED_10      2'h0
`define MPC_SPEED_100     2'h1
`define MPC_SPEED_1000    2'h2

// clock figures in kHz
`define MPC_MCLK_KHZ      125000
`define MPC_PLL_IN_KHZ    25000
`define MPC_PLL_MULT      10
`define MPC_SEC_DIV_A     2
`define MPC_SEC_DIV_B     5
`define MPC_GIG_KHZ       125000
`define MPC_MDIO_MAX_KHZ  2500
`define MPC_MDIO_TYP_KHZ  1000

// peripheral clock is the processor clock over this ratio
`define MPC_PERIPH_RATIO  6
`define MPC_PERIPH_HALF   8'h03
`define MPC_PERIPH_KHZ    (`MPC_MCLK_KHZ / `MPC_PERIPH_RATIO)

// least management half period, in peripheral ticks, rounded up
`define MPC_MDIO_MIN_HALF ((`MPC_PERIPH_KHZ + 2 * `MPC_MDIO_MAX_KHZ - 1) / (2 * `MPC_MDIO_MAX_KHZ))

// rmii data phase at 10 Mbps: one in this many reference edges
`define MPC_RMII_SLOW_DIV 4'ha

// sync settle cycles before the select pins are captured
`define MPC_STRAP_WAIT    3'h4

`endif

// ---- hdl/mpc_divider.v ----
// tick-driven clock divider with a rise strobe
`timescale 1ns/1ns
module mpc_divider (
   // clock and reset
   input  wire       mclk_i,
   input  wire       reset_i,
   // control
   input  wire       run_i,
   input  wire       tick_i,
   input  wire [7:0] half_i,
   // outputs
   output reg        clk_o,
   output reg        rise_o
);

   reg  [7:0] count;
   wire       wrap;

   assign wrap = (count + 8'h01 >= half_i);

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         count  <= 8'h00;
         clk_o  <= 1'b0;
         rise_o <= 1'b0;
      end else if (!run_i) begin
         count  <= 8'h00;
         clk_o  <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         rise_o <= 1'b0;
         if (tick_i) begin
            if (wrap) begin
               count  <= 8'h00;
               clk_o  <= ~clk_o;
               rise_o <= ~clk_o;
            end else begin
               count <= count + 8'h01;
            end
         end
      end
   end

endmodule // mpc_divider

// ---- testbench/mpc_clock_control_assertions.sv ----
// assertions on the clocking block ports
`timescale 1ns/1ns
module mpc_clock_control_assertions (
   // clock and reset
   input wire       mclk_i,
   input wire       reset_i,
   // watched ports
   input wire [1:0] line_speed_i,
   input wire       sec_div_five_i,
   input wire       peripheral_clock_o,
   input wire       mdio_clock_o,
   input wire       gigabit_tx_clock_out_o,
   input wire       rgmii_reference_clock_o,
   input wire       tx_phase_o,
   input wire [3:0] interface_active_o,
   input wire [1:0] line_speed_o,
   input wire       config_error_o,
   input wire       sec_div_mismatch_o
);
   wire [3:0] act = interface_active_o;
   reg        mdio_d;
   reg [10:0] mdio_idle;
   // cycles since the management clock last changed
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mdio_d    <= 1'b0;
         mdio_idle <= 11'h000;
      end else begin
         mdio_d <= mdio_clock_o;
         if (mdio_clock_o != mdio_d)
            mdio_idle <= 11'h000;
         else if (mdio_idle != 11'h7ff)
            mdio_idle <= mdio_idle + 11'h001;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sequence hi3_s; peripheral_clock_o [*3]; endsequence
   sequence lo3_s; !peripheral_clock_o [*3]; endsequence
   periph_ratio_a: assert property (
      $rose(peripheral_clock_o) |-> hi3_s ##1 lo3_s) else $error("peripheral clock ratio");
   periph_runs_a: assert property (
      lo3_s |=> peripheral_clock_o) else $error("peripheral clock stopped");
   mdio_slow_a: assert property (
      $changed(mdio_clock_o) |=> $stable(mdio_clock_o) [*8]) else $error("mdio clock fast");
   mdio_alive_a: assert property (
      mdio_idle < 11'd1600) else $error("mdio clock stopped");
   one_iface_a: assert property (
      $onehot0(act) && (act != 4'h0 || !tx_phase_o)) else $error("interface not one-hot");
   iface_static_a: assert property (
      act != 4'h0 |=> $stable(act)) else $error("interface changed");
   ref_reset_a: assert property (disable iff (1'b0)
      reset_i |-> !rgmii_reference_clock_o) else $error("reference clock in reset");
   ref_rgmii_a: assert property (
      !act[3] |-> !rgmii_reference_clock_o) else $error("reference clock outside rgmii");
   gig_source_a: assert property (
      act[1:0] != 2'h0 |-> !gigabit_tx_clock_out_o) else $error("gigabit clock in mii");
   slow_cfg_a: assert property (
      act[1:0] != 2'h0 && line_speed_i == 2'h2 && $stable(act)
      |=> config_error_o && line_speed_o == 2'h1) else $error("1000 in mii not flagged");
   div_match_a: assert property (
      (act[2] && sec_div_five_i || act[3] && !sec_div_five_i) && $stable(act)
      |=> sec_div_mismatch_o) else $error("divider mismatch not flagged");
endmodule // mpc_clock_control_assertions

// ---- testbench/mpc_phy_model.sv ----
// behavioural phy: bursts of line and reference clocks, idle low between
`timescale 1ns/1ns
module mpc_phy_model (
   // clock and control
   input  wire       mclk_i,
   input  wire [3:0] go_i,
   input  wire [7:0] count_i,
   input  wire [1:0] band_speed_i,
   // tx line, rx line, rmii reference, secondary reference
   output wire [3:0] clk_o,
   // rgmii receive, always between frames
   output wire       rx_ctl_o,
   output wire [3:0] rxd_o
);
   assign rx_ctl_o = 1'b0;
   assign rxd_o    = {1'b0, band_speed_i, 1'b0};
   genvar g;
   for (g = 0; g < 4; g = g + 1) begin : gen_burst
      reg line = 1'b0;
      assign clk_o[g] = line;
      initial begin
         forever begin
            @(posedge go_i[g]);
            repeat (count_i) begin
               @(posedge mclk_i);
               #1 line = 1'b1;
               repeat (5) @(posedge mclk_i);
               #1 line = 1'b0;
               repeat (4) @(posedge mclk_i);
            end
         end
      end
   end
endmodule // mpc_phy_model

// ---- testbench/test_mac_phy_interface_clocking.sv ----
// self-checking bench for the clocking block
`timescale 1ns/1ns
module test_mac_phy_interface_clocking;
   reg        mclk_i = 1'b0;
   reg        reset_i = 1'b1;
   reg  [1:0] phy_interface_select_i = 2'h0;
   reg  [1:0] line_speed_i = 2'h0;
   reg        sec_div_five_i = 1'b0;
   reg  [7:0] mdio_half_div_i = 8'h05;
   reg  [3:0] go = 4'h0;
   reg  [7:0] count = 8'h01;
   reg  [1:0] band = 2'h0;
   reg        meas = 1'b0;
   reg  [7:0] k, n_tx, n_rx, n_gig, n_ref;
   reg        gig_d, ref_d;
   reg [39:0] exp_q[$];
   reg [39:0] got;
   reg [31:0] seed = 32'd50;
   integer    n_errors = 0;
   integer    comparisons = 0;
   wire [3:0] pclk;
   wire       tx_line_clock_in_i = pclk[0];
   wire       rx_line_clock_in_i = pclk[1];
   wire       rmii_reference_clock_in_i = pclk[2];
   wire       secondary_reference_clock_i = pclk[3];
   wire       rgmii_rx_ctl_i, gigabit_tx_clock_out_o, rgmii_reference_clock_o;
   wire       peripheral_clock_o, mdio_clock_o, tx_phase_o, rx_phase_o;
   wire       config_error_o, sec_div_mismatch_o;
   wire [3:0] rgmii_rxd_i, interface_active_o;
   wire [1:0] line_speed_o;
   mpc_clock_control mpc_clock_control_i (
      .mclk_i                      (mclk_i),
      .reset_i                     (reset_i),
      .phy_interface_select_i      (phy_interface_select_i),
      .tx_line_clock_in_i          (tx_line_clock_in_i),
      .rx_line_clock_in_i          (rx_line_clock_in_i),
      .rmii_reference_clock_in_i   (rmii_reference_clock_in_i),
      .secondary_reference_clock_i (secondary_reference_clock_i),
      .rgmii_rx_ctl_i              (rgmii_rx_ctl_i),
      .rgmii_rxd_i                 (rgmii_rxd_i),
      .line_speed_i                (line_speed_i),
      .sec_div_five_i              (sec_div_five_i),
      .mdio_half_div_i             (mdio_half_div_i),
      .gigabit_tx_clock_out_o      (gigabit_tx_clock_out_o),
      .rgmii_reference_clock_o     (rgmii_reference_clock_o),
      .peripheral_clock_o          (peripheral_clock_o),
      .mdio_clock_o                (mdio_clock_o),
      .tx_phase_o                  (tx_phase_o),
      .rx_phase_o                  (rx_phase_o),
      .interface_active_o          (interface_active_o),
      .line_speed_o                (line_speed_o),
      .config_error_o              (config_error_o),
      .sec_div_mismatch_o          (sec_div_mismatch_o)
   );
   mpc_phy_model mpc_phy_model_i (
      .mclk_i       (mclk_i),
      .go_i         (go),
      .count_i      (count),
      .band_speed_i (band),
      .clk_o        (pclk),
      .rx_ctl_o     (rgmii_rx_ctl_i),
      .rxd_o        (rgmii_rxd_i)
   );
   initial forever #4 mclk_i = ~mclk_i;
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task test_done;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // straps are captured once, so each interface gets its own reset
   task rst(input [1:0] sel);
      @(posedge mclk_i);
      #1 reset_i = 1'b1;
      phy_interface_select_i = sel;
      mdio_half_div_i = 8'(rnd());
      repeat (8) @(posedge mclk_i);
      #1 reset_i = 1'b0;
      repeat (20) @(posedge mclk_i);
   endtask
   task run(input [1:0] spd, input five, input [3:0] g, input [7:0] n, input [39:0] e);
      @(posedge mclk_i);
      #1 line_speed_i = spd;
      sec_div_five_i = five;
      count = n;
      exp_q.push_back(e);
      @(posedge mclk_i);
      #1 go = g;
      @(posedge mclk_i);
      #1 go = 4'h0;
      repeat (10 * n + 40) @(posedge mclk_i);
      #1 meas = 1'b1;
      @(posedge mclk_i);
      #1 meas = 1'b0;
   endtask
   // counts phase pulses and forwarded clock rises, compares at each measure
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         {n_tx, n_rx, n_gig, n_ref, gig_d, ref_d} <= 34'h0;
      end else begin
         if (meas) begin
            got = {n_tx, n_rx, n_gig, n_ref, interface_active_o, line_speed_o,
                   config_error_o, sec_div_mismatch_o};
            comparisons = comparisons + 1;
            if (got !== exp_q[0]) begin
               n_errors = n_errors + 1;
               $display("mismatch at %0t: got %h expected %h", $time, got, exp_q[0]);
            end
            void'(exp_q.pop_front());
            {n_tx, n_rx, n_gig, n_ref} <= 32'h0;
         end else begin
            n_tx <= n_tx + tx_phase_o;
            n_rx <= n_rx + rx_phase_o;
            n_gig <= n_gig + (gigabit_tx_clock_out_o & ~gig_d);
            n_ref <= n_ref + (rgmii_reference_clock_o & ~ref_d);
         end
         gig_d <= gigabit_tx_clock_out_o;
         ref_d <= rgmii_reference_clock_o;
      end
   end
   initial begin
      #300000;
      n_errors = n_errors + 1;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done;
   end
   initial begin
      k = 8'h03 + 8'(rnd() % 8);
      rst(2'h0);
      run(2'h1, 1'b0, 4'h3, k, {k, k, 16'h0000, 8'h14});
      run(2'h2, 1'b0, 4'h0, k, {32'h0, 8'h16});
      rst(2'h1);
      run(2'h1, 1'b0, 4'h4, k, {k, k, 16'h0000, 8'h24});
      run(2'h1, 1'b0, 4'h3, k, {32'h0, 8'h24});
      run(2'h0, 1'b0, 4'h4, 8'(10 * k), {k, k, 16'h0000, 8'h20});
      rst(2'h2);
      run(2'h2, 1'b0, 4'ha, k, {k, k, k, 8'h00, 8'h48});
      run(2'h1, 1'b1, 4'h3, k, {k, k, 16'h0000, 8'h45});
      band = 2'h2;
      rst(2'h3);
      run(2'h1, 1'b1, 4'ha, k, {k, k, k, k, 8'h88});
      band = 2'h1;
      run(2'h0, 1'b0, 4'h2, k, {8'h00, k, 16'h0000, 8'h85});
      rst(2'h0);
      test_done;
   end
endmodule // test_mac_phy_interface_clocking
bind mpc_clock_control mpc_clock_control_assertions mpc_clock_control_assertions_i (
   .mclk_i                  (mclk_i),
   .reset_i                 (reset_i),
   .line_speed_i            (line_speed_i),
   .sec_div_five_i          (sec_div_five_i),
   .peripheral_clock_o      (peripheral_clock_o),
   .mdio_clock_o            (mdio_clock_o),
   .gigabit_tx_clock_out_o  (gigabit_tx_clock_out_o),
   .rgmii_reference_clock_o (rgmii_reference_clock_o),
   .tx_phase_o              (tx_phase_o),
   .interface_active_o      (interface_active_o),
   .line_speed_o            (line_speed_o),
   .config_error_o          (config_error_o),
   .sec_div_mismatch_o      (sec_div_mismatch_o)
);
